/* rac_pkg.sv */
// Purpose: Constants shared by the real-time clock alarm and control block.
// Assumes: Byte-wide register port; offsets are register indices on that port.
// Notes: Count registers live outside; only alarm and control registers are held here.
package rac_pkg;
  localparam logic [7:0] ADDR_ALARM_SECONDS = 8'hE8;
  localparam logic [7:0] ADDR_ALARM_MINUTES = 8'hE9;
  localparam logic [7:0] ADDR_ALARM_HOURS = 8'hEA;
  localparam logic [7:0] ADDR_ALARM_WEEKDAY = 8'hEB;
  localparam logic [7:0] ADDR_ALARM_FIELD_ENABLES = 8'hEC;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_STATUS = 8'hED;
  localparam int CTL_ALARM_FLAG_BIT = 7;
  localparam int CTL_INT_ENABLE_BIT = 6;
  localparam int CTL_BCD_MODE_BIT = 5;
  localparam int CTL_CLOCK_SOURCE_BIT = 4;
  localparam int CTL_LINE_FREQ_SELECT_BIT = 3;
  localparam int CTL_SLEEP_WAKE_CAUSE_BIT = 1;
  localparam int CTL_UNLOCK_BIT = 0;
  localparam int EN_WEEKDAY_BIT = 3;
  localparam int EN_HOUR_BIT = 2;
  localparam int EN_MINUTE_BIT = 1;
  localparam int EN_SECOND_BIT = 0;
  localparam logic [3:0] ALARM_ENABLES_RESET = 4'h0;
  localparam int CRYSTAL_DIVIDE = 32768;
  localparam int LINE_60HZ_DIVIDE = 60;
  localparam int LINE_50HZ_DIVIDE = 50;
  localparam logic [14:0] CRYSTAL_TERMINAL = 15'(CRYSTAL_DIVIDE - 1);
  localparam logic [14:0] LINE_60HZ_TERMINAL = 15'(LINE_60HZ_DIVIDE - 1);
  localparam logic [14:0] LINE_50HZ_TERMINAL = 15'(LINE_50HZ_DIVIDE - 1);
endpackage

/* rac_alarm_control.sv */
// Purpose: Alarm set points, alarm match, control register and clock prescaler of an RTC.
// Assumes: Time counter lives outside and reports its fields and an increment pulse.
// Notes: Source clock edges arrive on pins and are synchronised before use.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module rac_alarm_control
  import rac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] cur_seconds_i,
  input wire logic [7:0] cur_minutes_i,
  input wire logic [7:0] cur_hours_i,
  input wire logic [3:0] cur_weekday_i,
  input wire logic count_inc_i,
  input wire logic sleeping_i,
  input wire logic crystal_clk_i,
  input wire logic line_clk_i,
  output logic second_tick_o,
  output logic count_enable_o,
  output logic count_write_enable_o,
  output logic bcd_mode_o,
  output logic crystal_enable_o,
  output logic alarm_irq_o,
  output logic sleep_wake_req_o
);

  typedef struct packed {
    logic [7:0] alarm_seconds;
    logic [7:0] alarm_minutes;
    logic [7:0] alarm_hours;
    logic [3:0] alarm_weekday_value;
    logic [3:0] alarm_enables;
    logic alarm_flag;
    logic int_enable;
    logic bcd_mode;
    logic clock_source;
    logic line_freq_select;
    logic sleep_wake_cause;
    logic unlock;
    logic [1:0] xtal_sync;
    logic [1:0] line_sync;
    logic src_prev;
    logic [14:0] prescale;
    logic second_tick;
    logic sleep_wake_req;
    logic alarm_irq;
    logic count_enable;
    logic crystal_enable;
    logic [7:0] rdata;
  } rac_state_type;

  rac_state_type state_q;
  rac_state_type state_d;
  logic alarm_match;
  logic src_level;
  logic src_edge;
  logic [14:0] terminal;
  logic relock;

  // Enabled fields must all match; a register of all-zero enables never fires.
  always_comb
  begin
    alarm_match = (state_q.alarm_enables != 4'h0)
      && (!state_q.alarm_enables[EN_SECOND_BIT] || state_q.alarm_seconds == cur_seconds_i)
      && (!state_q.alarm_enables[EN_MINUTE_BIT] || state_q.alarm_minutes == cur_minutes_i)
      && (!state_q.alarm_enables[EN_HOUR_BIT] || state_q.alarm_hours == cur_hours_i)
      && (!state_q.alarm_enables[EN_WEEKDAY_BIT]
          || state_q.alarm_weekday_value == cur_weekday_i);
    src_level = state_q.clock_source ? state_q.line_sync[1] : state_q.xtal_sync[1];
    src_edge = src_level && !state_q.src_prev;
    if (!state_q.clock_source)
    begin
      terminal = CRYSTAL_TERMINAL;
    end
    else if (state_q.line_freq_select)
    begin
      terminal = LINE_50HZ_TERMINAL;
    end
    else
    begin
      terminal = LINE_60HZ_TERMINAL;
    end
    relock = wr_i && addr_i == ADDR_CLOCK_CONTROL_STATUS
      && state_q.unlock && !wdata_i[CTL_UNLOCK_BIT];
  end

  always_comb
  begin
    state_d = state_q;
    state_d.xtal_sync = {state_q.xtal_sync[0], crystal_clk_i};
    state_d.line_sync = {state_q.line_sync[0], line_clk_i};
    state_d.src_prev = src_level;
    state_d.second_tick = 1'b0;
    state_d.sleep_wake_req = 1'b0;
    // Prescaler only runs while locked, so counting stops when unlocked.
    if (src_edge && !state_q.unlock)
    begin
      if (state_q.prescale >= terminal)
      begin
        state_d.prescale = 15'h0000;
        state_d.second_tick = 1'b1;
      end
      else
      begin
        state_d.prescale = state_q.prescale + 15'h0001;
      end
    end
    // Flag is sampled only at re-lock or count increment; a read clears it.
    if (rd_i && addr_i == ADDR_CLOCK_CONTROL_STATUS)
    begin
      state_d.alarm_flag = 1'b0;
      state_d.sleep_wake_cause = 1'b0;
    end
    if (relock || count_inc_i)
    begin
      if (alarm_match)
      begin
        state_d.alarm_flag = 1'b1;
        if (sleeping_i)
        begin
          state_d.sleep_wake_req = 1'b1;
          state_d.sleep_wake_cause = 1'b1;
        end
      end
    end
    if (wr_i)
    begin
      case (addr_i)
        ADDR_ALARM_SECONDS: state_d.alarm_seconds = wdata_i;
        ADDR_ALARM_MINUTES: state_d.alarm_minutes = wdata_i;
        ADDR_ALARM_HOURS: state_d.alarm_hours = wdata_i;
        ADDR_ALARM_WEEKDAY:
        begin
          if (state_q.unlock)
          begin
            state_d.alarm_weekday_value = wdata_i[3:0];
          end
        end
        ADDR_ALARM_FIELD_ENABLES: state_d.alarm_enables = wdata_i[3:0];
        ADDR_CLOCK_CONTROL_STATUS:
        begin
          state_d.int_enable = wdata_i[CTL_INT_ENABLE_BIT];
          state_d.bcd_mode = wdata_i[CTL_BCD_MODE_BIT];
          state_d.clock_source = wdata_i[CTL_CLOCK_SOURCE_BIT];
          state_d.line_freq_select = wdata_i[CTL_LINE_FREQ_SELECT_BIT];
          state_d.unlock = wdata_i[CTL_UNLOCK_BIT];
          state_d.prescale = 15'h0000;
        end
        default:
        begin
        end
      endcase
    end
    state_d.alarm_irq = state_d.alarm_flag && state_d.int_enable;
    // Mirrors are registered so that every output leaves a flip-flop directly.
    state_d.count_enable = !state_d.unlock;
    state_d.crystal_enable = !state_d.clock_source;
    state_d.rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        ADDR_ALARM_SECONDS: state_d.rdata = state_q.alarm_seconds;
        ADDR_ALARM_MINUTES: state_d.rdata = state_q.alarm_minutes;
        ADDR_ALARM_HOURS: state_d.rdata = state_q.alarm_hours;
        ADDR_ALARM_WEEKDAY: state_d.rdata = {4'h0, state_q.alarm_weekday_value};
        ADDR_ALARM_FIELD_ENABLES: state_d.rdata = {4'h0, state_q.alarm_enables};
        ADDR_CLOCK_CONTROL_STATUS:
        begin
          state_d.rdata = {state_q.alarm_flag, state_q.int_enable, state_q.bcd_mode,
            state_q.clock_source, state_q.line_freq_select, 1'b0,
            state_q.sleep_wake_cause, state_q.unlock};
        end
        default: state_d.rdata = 8'h00;
      endcase
    end
  end

  // Reset touches only the bits that are documented to clear; the rest take their next-state value, so writes still land.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_q.alarm_enables <= ALARM_ENABLES_RESET;
      state_q.int_enable <= 1'b0;
      state_q.unlock <= 1'b0;
      state_q.xtal_sync <= 2'h0;
      state_q.line_sync <= 2'h0;
      state_q.src_prev <= 1'b0;
      state_q.prescale <= 15'h0000;
      state_q.second_tick <= 1'b0;
      state_q.sleep_wake_req <= 1'b0;
      state_q.alarm_irq <= 1'b0;
      state_q.count_enable <= 1'b1;
      state_q.crystal_enable <= !state_d.clock_source;
      state_q.rdata <= 8'h00;
      state_q.alarm_weekday_value <= state_d.alarm_weekday_value;
      state_q.alarm_seconds <= state_d.alarm_seconds;
      state_q.alarm_minutes <= state_d.alarm_minutes;
      state_q.alarm_hours <= state_d.alarm_hours;
      state_q.alarm_flag <= state_d.alarm_flag;
      state_q.bcd_mode <= state_d.bcd_mode;
      state_q.clock_source <= state_d.clock_source;
      state_q.line_freq_select <= state_d.line_freq_select;
      state_q.sleep_wake_cause <= state_d.sleep_wake_cause;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign rdata_o = state_q.rdata;
  assign second_tick_o = state_q.second_tick;
  assign count_enable_o = state_q.count_enable;
  assign count_write_enable_o = state_q.unlock;
  assign bcd_mode_o = state_q.bcd_mode;
  assign crystal_enable_o = state_q.crystal_enable;
  assign alarm_irq_o = state_q.alarm_irq;
  assign sleep_wake_req_o = state_q.sleep_wake_req;

  sequence read_ctl_seq;
    rd_i && addr_i == ADDR_CLOCK_CONTROL_STATUS && !count_inc_i;
  endsequence

  chk_read_clears_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    read_ctl_seq |=> !alarm_irq_o && !state_q.alarm_flag)
    else $error("Control read did not clear alarm flag.");
  chk_irq_gated_enable: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alarm_irq_o |-> state_q.int_enable && state_q.alarm_flag)
    else $error("Interrupt raised while disabled.");
  chk_flag_sets_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !$past(state_q.alarm_flag) && state_q.alarm_flag |-> $past(relock || count_inc_i))
    else $error("Alarm flag set outside update event.");
  chk_weekday_locked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ADDR_ALARM_WEEKDAY && !state_q.unlock
      |=> $stable(state_q.alarm_weekday_value))
    else $error("Weekday written while locked.");
  chk_prescale_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ADDR_CLOCK_CONTROL_STATUS |=> state_q.prescale == 15'h0000)
    else $error("Control write did not reset prescaler.");
  chk_no_count_unlock: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q.unlock |=> !second_tick_o)
    else $error("Prescaler ticked while unlocked.");
  chk_ctl_bit2_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_i && addr_i == ADDR_CLOCK_CONTROL_STATUS |=> rdata_o[2] == 1'b0)
    else $error("Reserved control bit read nonzero.");
  chk_weekday_upper: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_i && addr_i == ADDR_ALARM_WEEKDAY |=> rdata_o[7:4] == 4'h0)
    else $error("Weekday reserved nibble nonzero.");
  chk_enables_upper: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_i && addr_i == ADDR_ALARM_FIELD_ENABLES |=> rdata_o[7:4] == 4'h0)
    else $error("Enable reserved nibble nonzero.");
  chk_wake_sets_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sleep_wake_req_o |-> state_q.sleep_wake_cause && state_q.alarm_flag)
    else $error("Wake request without cause bit.");
  chk_hours_rw: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ADDR_ALARM_HOURS ##1 rd_i && addr_i == ADDR_ALARM_HOURS
      |=> rdata_o == $past(wdata_i, 2))
    else $error("Alarm hours did not read back.");

  // An update event is a re-lock or a count increment; it is the only moment of evaluation.
  sequence update_seq;
    (relock || count_inc_i) && alarm_match;
  endsequence

  sequence ctl_write_seq;
    wr_i && addr_i == ADDR_CLOCK_CONTROL_STATUS;
  endsequence

  // A matching update must raise the flag, even if a control read falls in the same cycle.
  chk_flag_on_match: assert property (@(posedge clk_i) disable iff (!rstn_i)
    update_seq |=> state_q.alarm_flag)
    else $error("Matching update did not raise the alarm flag.");

  // With every enable cleared the comparison must never report a match.
  chk_no_match_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q.alarm_enables == 4'h0 |-> !alarm_match)
    else $error("Match reported with no field enabled.");

  // A match while asleep asks for recovery in the next cycle.
  chk_wake_when_asleep: assert property (@(posedge clk_i) disable iff (!rstn_i)
    update_seq ##0 sleeping_i |=> sleep_wake_req_o)
    else $error("Asleep match gave no wake request.");

  // Without an asleep match no recovery request may appear.
  chk_no_wake_awake: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !((relock || count_inc_i) && alarm_match && sleeping_i) |=> !sleep_wake_req_o)
    else $error("Wake request without an asleep match.");

  // The enable register takes the low nibble of every write to it.
  chk_enables_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ADDR_ALARM_FIELD_ENABLES
      |=> state_q.alarm_enables == $past(wdata_i[3:0]))
    else $error("Enable register did not take the write.");

  // Alarm hours are writable whatever the lock state.
  chk_hours_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ADDR_ALARM_HOURS |=> state_q.alarm_hours == $past(wdata_i))
    else $error("Alarm hours did not take the write.");

  // Alarm seconds take the whole byte, tens digit in the upper nibble.
  chk_seconds_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ADDR_ALARM_SECONDS |=> state_q.alarm_seconds == $past(wdata_i))
    else $error("Alarm seconds did not take the write.");

  // Alarm minutes take the whole byte, tens digit in the upper nibble.
  chk_minutes_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ADDR_ALARM_MINUTES |=> state_q.alarm_minutes == $past(wdata_i))
    else $error("Alarm minutes did not take the write.");

  // While unlocked the weekday field must accept the write.
  chk_weekday_unlocked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ADDR_ALARM_WEEKDAY && state_q.unlock
      |=> state_q.alarm_weekday_value == $past(wdata_i[3:0]))
    else $error("Weekday not written while unlocked.");

  // The BCD output follows the bit written into the control register.
  chk_bcd_follows: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctl_write_seq |=> bcd_mode_o == $past(wdata_i[CTL_BCD_MODE_BIT]))
    else $error("BCD mode did not follow the control write.");

  // The crystal runs exactly when the line source is not selected.
  chk_crystal_select: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctl_write_seq |=> crystal_enable_o == !$past(wdata_i[CTL_CLOCK_SOURCE_BIT]))
    else $error("Crystal enable does not match the source bit.");

  // Counting stops whenever the count registers are open for writing.
  chk_count_mirror: assert property (@(posedge clk_i) disable iff (!rstn_i)
    count_enable_o == !count_write_enable_o)
    else $error("Count enable and write enable disagree.");

  // In line mode the prescaler never passes the selected line divisor.
  chk_prescale_60hz: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q.clock_source && !state_q.line_freq_select
      |-> state_q.prescale <= LINE_60HZ_TERMINAL)
    else $error("Prescaler passed the 60 Hz divisor.");
  chk_prescale_50hz: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q.clock_source && state_q.line_freq_select
      |-> state_q.prescale <= LINE_50HZ_TERMINAL)
    else $error("Prescaler passed the 50 Hz divisor.");
endmodule
`default_nettype wire

/* rac_alarm_control_tb.sv */
// Purpose: Self-checking bench for the RTC alarm and control block over its register port.
// Assumes: Counter fields and the count increment pulse are driven by the bench.
// Notes: The crystal input is held low; the prescaler is exercised through the line input.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rac_pkg::*;
  logic clk_i, rstn_i, wr_i, rd_i, inc, slp, line_clk;
  logic [7:0] addr_i, wdata_i, rdata_o, hrs, rv;
  logic tick, cen, cwe, bcd, xen, irq, wake;
  int failures = 0, check_count = 0, ticks = 0, cycles = 0;
  rac_alarm_control rac_alarm_control_inst (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cur_seconds_i(8'h00),
    .cur_minutes_i(8'h00), .cur_hours_i(hrs), .cur_weekday_i(4'h0), .count_inc_i(inc),
    .sleeping_i(slp), .crystal_clk_i(1'b0), .line_clk_i(line_clk), .second_tick_o(tick),
    .count_enable_o(cen), .count_write_enable_o(cwe), .bcd_mode_o(bcd),
    .crystal_enable_o(xen), .alarm_irq_o(irq), .sleep_wake_req_o(wake));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rst();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask
  task automatic edges(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      line_clk <= 1'b1;
      repeat (4) @(posedge clk_i);
      line_clk <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask
  task automatic alarm(input logic asleep);
    @(posedge clk_i);
    slp <= asleep;
    inc <= 1'b1;
    @(posedge clk_i);
    inc <= 1'b0;
    #1 chk1("wake_req", asleep, wake);
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (tick === 1'b1)
      ticks++;
    if (cycles == 6000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    {rstn_i, wr_i, rd_i, inc, slp, line_clk} = 6'h00;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    hrs = 8'h00;
    rst();
    rd(ADDR_ALARM_FIELD_ENABLES, rv); chk8("enables_rst", 8'h00, rv);
    rd(ADDR_CLOCK_CONTROL_STATUS, rv); chk8("ctl_rst", 8'h00, rv & 8'h45);
    chk1("count_en", 1'b1, cen);
    chk1("count_wr_en", 1'b0, cwe);
    wr(ADDR_CLOCK_CONTROL_STATUS, 8'h00);
    rd(ADDR_CLOCK_CONTROL_STATUS, rv);
    rd(ADDR_CLOCK_CONTROL_STATUS, rv); chk8("ctl_clear", 8'h00, rv);
    wr(ADDR_ALARM_HOURS, 8'h23);
    rd(ADDR_ALARM_HOURS, rv); chk8("hours", 8'h23, rv);
    wr(ADDR_ALARM_FIELD_ENABLES, 8'hFF);
    rd(ADDR_ALARM_FIELD_ENABLES, rv); chk8("enables", 8'h0F, rv);
    wr(ADDR_CLOCK_CONTROL_STATUS, 8'h01);
    #1 chk1("unlocked_wr_en", 1'b1, cwe);
    chk1("unlocked_cnt_en", 1'b0, cen);
    wr(ADDR_ALARM_WEEKDAY, 8'hF3);
    wr(ADDR_CLOCK_CONTROL_STATUS, 8'h00);
    wr(ADDR_ALARM_WEEKDAY, 8'h06);
    rd(ADDR_ALARM_WEEKDAY, rv); chk8("weekday_locked", 8'h03, rv);
    rst();
    rd(ADDR_ALARM_FIELD_ENABLES, rv); chk8("enables_rst2", 8'h00, rv);
    rd(ADDR_ALARM_HOURS, rv); chk8("hours_kept", 8'h23, rv);
    rd(ADDR_ALARM_WEEKDAY, rv); chk8("weekday_kept", 8'h03, rv);
    $display("test registers done");
    wr(ADDR_ALARM_FIELD_ENABLES, 8'h04);
    wr(ADDR_CLOCK_CONTROL_STATUS, 8'h40);
    hrs <= 8'h23;
    repeat (3) @(posedge clk_i);
    #1 chk1("irq_no_inc", 1'b0, irq);
    alarm(1'b1);
    chk1("irq_set", 1'b1, irq);
    slp <= 1'b0;
    rd(ADDR_CLOCK_CONTROL_STATUS, rv); chk8("ctl_alarm", 8'hC2, rv);
    chk1("irq_cleared", 1'b0, irq);
    rd(ADDR_CLOCK_CONTROL_STATUS, rv); chk8("ctl_after_rd", 8'h40, rv);
    alarm(1'b0);
    rd(ADDR_CLOCK_CONTROL_STATUS, rv); chk8("ctl_awake", 8'hC0, rv);
    wr(ADDR_ALARM_SECONDS, 8'h05);
    wr(ADDR_ALARM_FIELD_ENABLES, 8'h01);
    alarm(1'b0);
    rd(ADDR_CLOCK_CONTROL_STATUS, rv); chk8("ctl_mismatch", 8'h40, rv);
    wr(ADDR_ALARM_FIELD_ENABLES, 8'h04);
    alarm(1'b1);
    rst();
    slp <= 1'b0;
    rd(ADDR_CLOCK_CONTROL_STATUS, rv); chk8("ctl_keep", 8'h82, rv);
    $display("test alarm done");
    wr(ADDR_CLOCK_CONTROL_STATUS, 8'h20);
    #1 chk1("bcd_mode", 1'b1, bcd);
    chk1("crystal_on", 1'b1, xen);
    for (int f = 0; f < 2; f++)
    begin
      wr(ADDR_CLOCK_CONTROL_STATUS, 8'h10 | 8'(f << 3));
      #1 chk1("crystal_off", 1'b0, xen);
      chk1("bcd_off", 1'b0, bcd);
      edges(10);
      wr(ADDR_CLOCK_CONTROL_STATUS, 8'h10 | 8'(f << 3));
      ticks = 0;
      edges((f != 0) ? LINE_50HZ_DIVIDE - 1 : LINE_60HZ_DIVIDE - 1);
      chk8("ticks_short", 8'h00, 8'(ticks));
      edges(1);
      chk8("ticks_full", 8'h01, 8'(ticks));
    end
    $display("test prescaler done");
    print_verdict();
  end
endmodule
`default_nettype wire
